// file: hdl/pll_dynamic_adjust_ctrl.sv
`timescale 1ns/10ps
//
// Operation
// [R1] each delay step rising edge moves taps once, unless reload is held
// [R2] direction 0 lowers the tap setting, 1 raises it
// [R3] step size 0 moves one tap, 1 moves two taps
// [R4] reload restores the programmed delay; fabric keeps reload low while tuning
// [R5] flag raised at lowest or highest tap; further steps stay at that limit
// [R6] fabric uses four separate picks, one per clock output
// [R7] phase shift rising edge moves each picked output one vco phase
// [R8] one shared shift pulse; only picked outputs respond
// [R9] falling edge of phase reload restores all programmed phases
// [R10] reconfiguration port runs on its own dedicated clock input; here that input is oversampled and the port logic runs on pclk
// [R11] 11-bit control, 33-bit write bus and 33-bit read bus, multiplexed
// [R12] reconfiguration logic resets asynchronously while its reset is low
// [R13] interrupt to master held until master services it
// [R14] reconfiguration signals sampled and driven on its clock rising edges; here on pclk, with reconf_irq set in any pclk cycle
module pll_dynamic_adjust_ctrl (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic [7:0]  paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   output logic             irq,
   input  wire logic        delay_step,
   input  wire logic        delay_dir,
   input  wire logic        delay_wide,
   input  wire logic        delay_reload,
   output logic             delay_limit_flag,
   input  wire logic        phase_pick_0,
   input  wire logic        phase_pick_1,
   input  wire logic        phase_pick_2,
   input  wire logic        phase_pick_3,
   input  wire logic        phase_dir,
   input  wire logic        phase_shift_pulse,
   input  wire logic        phase_reload_n,
   input  wire logic        reconf_clk,
   input  wire logic [10:0] reconf_ctrl,
   input  wire logic [32:0] reconf_wbus,
   input  wire logic        reconf_arst_n,
   output logic      [32:0] reconf_rbus,
   output logic             reconf_irq
);

   pll_adjust_pkg::delay_pins_type  dly_raw;
   pll_adjust_pkg::delay_pins_type  dly_s;
   pll_adjust_pkg::delay_pins_type  dly_q;
   pll_adjust_pkg::phase_pins_type  ph_raw;
   pll_adjust_pkg::phase_pins_type  ph_s;
   pll_adjust_pkg::phase_pins_type  ph_q;
   pll_adjust_pkg::reconf_pins_type rc_raw;
   pll_adjust_pkg::reconf_pins_type rc_s;
   pll_adjust_pkg::reconf_pins_type rc_q;
   logic [7:0]        tap;
   logic [7:0]        next_tap;
   logic              next_limit;
   logic [3:0][2:0]   phase;
   logic [3:0][2:0]   next_phase;
   logic [7:0]        init_tap;
   logic [7:0]        next_init_tap;
   logic [11:0]       init_phase;
   logic [11:0]       next_init_phase;
   logic [4:0]        status;
   logic [4:0]        next_status;
   logic [4:0]        mask;
   logic [4:0]        next_mask;
   logic [31:0]       next_prdata;
   logic              next_pslverr;
   logic [4:0]        events;
   logic              step_rise;
   logic              shift_rise;
   logic              reload_fall;
   logic              limit_event;
   logic              rc_rise;
   logic              rc_req;
   logic              rc_wr;
   logic              rc_ack;
   logic              rc_rst_n;
   logic [1:0]        rc_addr;
   logic [1:0]        next_rc_addr;
   logic [3:0][31:0]  rc_store;
   logic [3:0][31:0]  next_rc_store;
   logic [32:0]       next_rbus;
   logic              next_rc_irq;
   logic              apb_setup;
   logic              apb_write;

   assign dly_raw = '{step: delay_step, dir: delay_dir, wide: delay_wide, reload: delay_reload};
   assign ph_raw  = '{pick: {phase_pick_3, phase_pick_2, phase_pick_1, phase_pick_0},
                      dir: phase_dir, shift: phase_shift_pulse, reload_n: phase_reload_n};
   // [R10] own clock input
   assign rc_raw  = '{clk: reconf_clk, ctrl: reconf_ctrl, wbus: reconf_wbus};
   pin_sync #(
      .WIDTH ($bits(pll_adjust_pkg::delay_pins_type))
   ) u_dly_sync (
      .pclk    (pclk),
      .presetn (presetn),
      .d       (dly_raw),
      .q       (dly_s)
   );
   pin_sync #(
      .WIDTH ($bits(pll_adjust_pkg::phase_pins_type))
   ) u_ph_sync (
      .pclk    (pclk),
      .presetn (presetn),
      .d       (ph_raw),
      .q       (ph_s)
   );
   // the link clock travels through the same stages as its data, so bits stay aligned
   pin_sync #(
      .WIDTH ($bits(pll_adjust_pkg::reconf_pins_type))
   ) u_rc_sync (
      .pclk    (pclk),
      .presetn (presetn),
      .d       (rc_raw),
      .q       (rc_s)
   );
   assign step_rise   = dly_s.step & ~dly_q.step;
   assign shift_rise  = ph_s.shift & ~ph_q.shift;
   assign reload_fall = ~ph_s.reload_n & ph_q.reload_n;
   assign rc_rise     = rc_s.clk & ~rc_q.clk;
   // delay line tap control
   always_comb
   begin
      next_tap = tap;
      // [R4] reload wins over stepping
      if (dly_s.reload)
         next_tap = init_tap;
      // [R1] one move per rising step edge
      else if (step_rise)
      begin
         // [R2] [R3] direction and size, clamped at the ends
         if (dly_s.dir)
         begin
            if (dly_s.wide)
               next_tap = (tap >= pll_adjust_pkg::TAP_MAX - pll_adjust_pkg::TAP_TWO) ?
                          pll_adjust_pkg::TAP_MAX : tap + pll_adjust_pkg::TAP_TWO;
            else
               next_tap = (tap == pll_adjust_pkg::TAP_MAX) ?
                          pll_adjust_pkg::TAP_MAX : tap + pll_adjust_pkg::TAP_ONE;
         end
         else
         begin
            if (dly_s.wide)
               next_tap = (tap <= pll_adjust_pkg::TAP_MIN + pll_adjust_pkg::TAP_TWO) ?
                          pll_adjust_pkg::TAP_MIN : tap - pll_adjust_pkg::TAP_TWO;
            else
               next_tap = (tap == pll_adjust_pkg::TAP_MIN) ?
                          pll_adjust_pkg::TAP_MIN : tap - pll_adjust_pkg::TAP_ONE;
         end
      end
      // [R5] flag tracks the ends of the line
      next_limit  = (next_tap == pll_adjust_pkg::TAP_MIN) ||
                    (next_tap == pll_adjust_pkg::TAP_MAX);
      limit_event = next_limit & ~delay_limit_flag;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         tap              <= pll_adjust_pkg::TAP_INIT_RST;
         delay_limit_flag <= 1'b0;
         dly_q            <= '0;
      end
      else
      begin
         tap              <= next_tap;
         delay_limit_flag <= next_limit;
         dly_q            <= dly_s;
      end
   end

   // phase rotation
   always_comb
   begin
      next_phase = phase;
      // [R9] reload restores every output
      if (reload_fall)
      begin
         for (int i = 0; i < pll_adjust_pkg::OUT_N; i++)
            next_phase[i] = init_phase[i*pll_adjust_pkg::PHASE_W +: pll_adjust_pkg::PHASE_W];
      end
      // [R7] [R8] shared pulse, picked outputs only
      else if (shift_rise)
      begin
         for (int i = 0; i < pll_adjust_pkg::OUT_N; i++)
         begin
            if (ph_s.pick[i])
               next_phase[i] = ph_s.dir ? phase[i] + pll_adjust_pkg::PHASE_ONE :
                                          phase[i] - pll_adjust_pkg::PHASE_ONE;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         phase <= pll_adjust_pkg::PHASE_INIT_RST;
         ph_q  <= '{pick: 4'h0, dir: 1'b0, shift: 1'b0, reload_n: 1'b0};
      end
      else
      begin
         phase <= next_phase;
         ph_q  <= ph_s;
      end
   end

   // apb slave, zero wait states; read data registered in the setup cycle
   assign apb_setup = psel & ~penable;
   assign apb_write = psel & penable & pwrite;
   assign pready    = 1'b1;
   assign events    = {rc_rise & rc_req, reload_fall, shift_rise, limit_event, step_rise};
   assign irq       = |(status & mask);
   always_comb
   begin
      next_init_tap   = init_tap;
      next_init_phase = init_phase;
      next_mask       = mask;
      next_prdata     = prdata;
      next_pslverr    = pslverr;
      if (apb_write && paddr == pll_adjust_pkg::INIT_ADDR)
      begin
         next_init_tap   = pwdata[7:0];
         next_init_phase = pwdata[pll_adjust_pkg::INIT_PHASE_POS +: 12];
      end
      else if (apb_write && paddr == pll_adjust_pkg::IRQ_MASK_ADDR)
         next_mask = pwdata[4:0];
      // a new event in the clearing cycle stays set
      next_status = status & ~((apb_write && paddr == pll_adjust_pkg::IRQ_STATUS_ADDR) ?
                               pwdata[4:0] : 5'h00);
      next_status = next_status | events;
      if (apb_setup)
      begin
         next_pslverr = 1'b0;
         if (paddr == pll_adjust_pkg::DELAY_STATE_ADDR)
            next_prdata = {23'h0, delay_limit_flag, tap};
         else if (paddr == pll_adjust_pkg::PHASE_STATE_ADDR)
            next_prdata = {20'h0, phase};
         else if (paddr == pll_adjust_pkg::INIT_ADDR)
            next_prdata = {12'h0, init_phase, init_tap};
         else if (paddr == pll_adjust_pkg::IRQ_STATUS_ADDR)
            next_prdata = {27'h0, status};
         else if (paddr == pll_adjust_pkg::IRQ_MASK_ADDR)
            next_prdata = {27'h0, mask};
         else
         begin
            next_prdata  = 32'h0000_0000;
            next_pslverr = 1'b1;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         init_tap   <= pll_adjust_pkg::TAP_INIT_RST;
         init_phase <= pll_adjust_pkg::PHASE_INIT_RST;
         mask       <= pll_adjust_pkg::MASK_RST;
         status     <= 5'h00;
         prdata     <= 32'h0000_0000;
         pslverr    <= 1'b0;
      end
      else
      begin
         init_tap   <= next_init_tap;
         init_phase <= next_init_phase;
         mask       <= next_mask;
         status     <= next_status;
         prdata     <= next_prdata;
         pslverr    <= next_pslverr;
      end
   end

   // reconfiguration port; the sample before the detected edge is the setup value
   assign rc_req = rc_q.ctrl[pll_adjust_pkg::RC_REQ_BIT];
   assign rc_wr  = rc_q.ctrl[pll_adjust_pkg::RC_WRITE_BIT];
   assign rc_ack = rc_q.ctrl[pll_adjust_pkg::RC_ACK_BIT];
   // [R12] pin reset acts without any clock; release timing is the master's concern
   assign rc_rst_n = presetn & reconf_arst_n;
   always_comb
   begin
      next_rc_addr  = rc_addr;
      next_rc_store = rc_store;
      next_rbus     = reconf_rbus;
      next_rc_irq   = reconf_irq;
      // [R14] [R11] act on link rising edges only
      if (rc_rise && rc_req)
      begin
         if (rc_wr && rc_q.wbus[pll_adjust_pkg::RC_ADDR_FLAG])
            next_rc_addr = rc_q.wbus[1:0];
         else if (rc_wr)
            next_rc_store[rc_addr] = rc_q.wbus[31:0];
         else
            next_rbus = {1'b0, rc_store[rc_addr]};
      end
      // [R13] held until acknowledged; a new event beats the clear
      if (rc_rise && rc_ack)
         next_rc_irq = 1'b0;
      if (limit_event || reload_fall)
         next_rc_irq = 1'b1;
   end

   always_ff @(posedge pclk or negedge rc_rst_n)
   begin
      if (!rc_rst_n)
      begin
         rc_addr     <= 2'h0;
         rc_store    <= '0;
         reconf_rbus <= 33'h0_0000_0000;
         reconf_irq  <= 1'b0;
         rc_q        <= '0;
      end
      else
      begin
         rc_addr     <= next_rc_addr;
         rc_store    <= next_rc_store;
         reconf_rbus <= next_rbus;
         reconf_irq  <= next_rc_irq;
         rc_q        <= rc_s;
      end
   end

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   a_tap_hold_idle: assert property (!step_rise && !dly_s.reload |=> $stable(tap)) // [R1]
      else $error("tap moved without a step");
   a_tap_step_up: assert property (step_rise && dly_s.dir && !dly_s.wide && !dly_s.reload && // [R2]
      tap != pll_adjust_pkg::TAP_MAX |=> tap == $past(tap) + 8'h01)
      else $error("tap did not rise by one");
   a_tap_step_down: assert property (step_rise && !dly_s.dir && !dly_s.reload && // [R2]
      tap > 8'h02 |=> tap < $past(tap))
      else $error("tap did not fall");
   a_tap_wide_step: assert property (step_rise && dly_s.wide && dly_s.dir && !dly_s.reload && // [R3]
      tap < 8'hfd |=> tap == $past(tap) + 8'h02)
      else $error("wide step not two taps");
   a_tap_reload: assert property (dly_s.reload |=> tap == $past(init_tap)) // [R4]
      else $error("reload did not restore delay");
   a_tap_limit: assert property (tap == pll_adjust_pkg::TAP_MAX && dly_s.dir && // [R5]
      !dly_s.reload |=> tap == pll_adjust_pkg::TAP_MAX && delay_limit_flag)
      else $error("tap left the upper limit");
   a_phase_unpicked: assert property (!ph_s.pick[0] && !reload_fall |=> $stable(phase[0])) // [R8]
      else $error("unpicked output moved");
   a_phase_forward: assert property (shift_rise && ph_s.pick[0] && ph_s.dir && !reload_fall // [R7]
      |=> phase[0] == 3'($past(phase[0]) + 3'h1))
      else $error("picked output not advanced");
   a_phase_reload: assert property (reload_fall |=> phase == $past(init_phase)) // [R9]
      else $error("phase reload failed");
   a_irq_held: assert property (disable iff (!rc_rst_n) // [R13]
      reconf_irq && !(rc_rise && rc_ack) |=> reconf_irq)
      else $error("reconf irq dropped unserviced");
   a_rc_read: assert property (disable iff (!rc_rst_n) // [R11]
      rc_rise && rc_req && !rc_wr |=> reconf_rbus == {1'b0, $past(rc_store[rc_addr])})
      else $error("reconf read data wrong");
   c_hit_limit: cover property (step_rise ##1 delay_limit_flag);
   c_phase_shift: cover property (shift_rise && ph_s.pick[2]);
   c_rc_write_read: cover property (rc_rise && rc_req && rc_wr ##[1:100] rc_rise && rc_req && !rc_wr);
   c_irq_service: cover property (reconf_irq ##[1:200] !reconf_irq);

endmodule

// file: hdl/pll_adjust_pkg.sv
package pll_adjust_pkg;

   // register byte offsets
   localparam logic [7:0] DELAY_STATE_ADDR = 8'h00;
   localparam logic [7:0] PHASE_STATE_ADDR = 8'h04;
   localparam logic [7:0] INIT_ADDR        = 8'h08;
   localparam logic [7:0] IRQ_STATUS_ADDR  = 8'h0c;
   localparam logic [7:0] IRQ_MASK_ADDR    = 8'h10;

   // delay line
   localparam int         TAP_W        = 8;
   localparam logic [7:0] TAP_MIN      = 8'h00;
   localparam logic [7:0] TAP_MAX      = 8'hff;
   localparam logic [7:0] TAP_ONE      = 8'h01;
   localparam logic [7:0] TAP_TWO      = 8'h02;
   localparam logic [7:0] TAP_INIT_RST = 8'h80;
   localparam int         LIMIT_POS    = 8;

   // phase rotation: four outputs, eight vco phases each
   localparam int          OUT_N          = 4;
   localparam int          PHASE_W        = 3;
   localparam logic [2:0]  PHASE_ONE      = 3'h1;
   localparam logic [11:0] PHASE_INIT_RST = 12'h000;
   localparam int          INIT_PHASE_POS = 8;

   // sticky event bits
   localparam int         STATUS_W     = 5;
   localparam int         ST_STEP      = 0;
   localparam int         ST_LIMIT     = 1;
   localparam int         ST_SHIFT     = 2;
   localparam int         ST_PRELOAD   = 3;
   localparam int         ST_RECONF    = 4;
   localparam logic [4:0] MASK_RST     = 5'h00;

   // reconfiguration port encoding
   localparam int RC_REQ_BIT   = 0;
   localparam int RC_WRITE_BIT = 1;
   localparam int RC_ACK_BIT   = 2;
   localparam int RC_ADDR_FLAG = 32;
   localparam int RC_DEPTH     = 4;
   localparam int RC_AW        = 2;

   typedef struct packed {
      logic step;
      logic dir;
      logic wide;
      logic reload;
   } delay_pins_type;

   typedef struct packed {
      logic [3:0] pick;
      logic       dir;
      logic       shift;
      logic       reload_n;
   } phase_pins_type;

   typedef struct packed {
      logic        clk;
      logic [10:0] ctrl;
      logic [32:0] wbus;
   } reconf_pins_type;

endpackage

// file: hdl/pin_sync.sv
`timescale 1ns/10ps
module pin_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             pclk,
   input  wire logic             presetn,
   input  wire logic [WIDTH-1:0] d,
   output logic      [WIDTH-1:0] q
);

   logic [WIDTH-1:0] meta;

   // first stage feeds only the second stage
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         meta <= '0;
         q    <= '0;
      end
      else
      begin
         meta <= d;
         q    <= meta;
      end
   end

endmodule

// file: test/fabric_model.sv
`timescale 1ns/10ps
module fabric_model (
   input  wire logic        pclk,
   output logic             delay_step,
   output logic             delay_dir,
   output logic             delay_wide,
   output logic             delay_reload,
   output logic [3:0]       pick,
   output logic             phase_dir,
   output logic             phase_shift_pulse,
   output logic             phase_reload_n,
   output logic             reconf_clk,
   output logic [10:0]      reconf_ctrl,
   output logic [32:0]      reconf_wbus,
   output logic             reconf_arst_n
);
   initial
   begin
      {delay_step, delay_dir, delay_wide, delay_reload} = 4'h0;
      {pick, phase_dir, phase_shift_pulse} = 6'h00;
      phase_reload_n = 1'h1;
      reconf_clk = 1'h0;
      reconf_ctrl = 11'h000;
      reconf_wbus = 33'h0;
      reconf_arst_n = 1'h1;
   end

   task automatic hold(input int n);
      repeat (n) @(posedge pclk);
   endtask

   // one move, reload left as commanded
   task automatic step(input logic dir, input logic wide);
      @(posedge pclk);
      delay_dir <= dir;
      delay_wide <= wide;
      hold(4);
      delay_step <= 1'h1;
      hold(4);
      delay_step <= 1'h0;
      hold(6);
   endtask

   task automatic reload(input logic on);
      @(posedge pclk);
      delay_reload <= on;
      hold(6);
   endtask

   task automatic shift(input logic [3:0] p, input logic dir);
      @(posedge pclk);
      pick <= p;
      phase_dir <= dir;
      hold(4);
      phase_shift_pulse <= 1'h1;
      hold(4);
      phase_shift_pulse <= 1'h0;
      hold(6);
   endtask

   task automatic preload();
      @(posedge pclk);
      phase_reload_n <= 1'h0;
      hold(4);
      phase_reload_n <= 1'h1;
      hold(6);
   endtask

   // data held well before and after the rise
   task automatic link(input logic [10:0] c, input logic [32:0] w);
      @(posedge pclk);
      reconf_ctrl <= c;
      reconf_wbus <= w;
      // clock only runs inside a frame, out of phase with pclk
      #62.5 reconf_clk = 1'h1;
      #62.5 reconf_clk = 1'h0;
      @(posedge pclk);
      reconf_ctrl <= 11'h000;
      // released bus shows the inverse, never a stale copy
      reconf_wbus <= ~w;
      hold(4);
   endtask

   task automatic ack();
      link(11'h004, 33'h0);
   endtask

   task automatic arst();
      @(posedge pclk);
      reconf_arst_n <= 1'h0;
      hold(3);
      reconf_arst_n <= 1'h1;
      hold(3);
   endtask
endmodule

// file: test/tb_pll_dynamic_adjust_ctrl.sv
`timescale 1ns/10ps
module tb_pll_dynamic_adjust_ctrl;
   logic        pclk;
   logic        presetn;
   logic [7:0]  paddr;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        irq;
   logic        d_step;
   logic        d_dir;
   logic        d_wide;
   logic        d_reload;
   logic        d_flag;
   logic [3:0]  pick;
   logic        p_dir;
   logic        p_shift;
   logic        p_reload_n;
   logic        r_clk;
   logic [10:0] r_ctrl;
   logic [32:0] r_wbus;
   logic        r_arst_n;
   logic [32:0] r_rbus;
   logic        r_irq;
   logic [31:0] q;
   logic        e;
   int          fails;
   int          n_checks;
   logic [9:0]  steps [4] = '{10'h281, 10'h383, 10'h181, 10'h080};
   logic [16:0] shifts [4] = '{{4'h5, 1'h1, 12'h041}, {4'h2, 1'h0, 12'h079},
                               {4'h8, 1'h1, 12'h279}, {4'h0, 1'h1, 12'h279}};

   pll_dynamic_adjust_ctrl pll_dynamic_adjust_ctrl_inst (
      .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .irq(irq), .delay_step(d_step), .delay_dir(d_dir),
      .delay_wide(d_wide), .delay_reload(d_reload), .delay_limit_flag(d_flag),
      .phase_pick_0(pick[0]), .phase_pick_1(pick[1]), .phase_pick_2(pick[2]),
      .phase_pick_3(pick[3]), .phase_dir(p_dir), .phase_shift_pulse(p_shift),
      .phase_reload_n(p_reload_n), .reconf_clk(r_clk), .reconf_ctrl(r_ctrl),
      .reconf_wbus(r_wbus), .reconf_arst_n(r_arst_n), .reconf_rbus(r_rbus),
      .reconf_irq(r_irq));

   fabric_model fabric_model_inst (
      .pclk(pclk), .delay_step(d_step), .delay_dir(d_dir), .delay_wide(d_wide),
      .delay_reload(d_reload), .pick(pick), .phase_dir(p_dir),
      .phase_shift_pulse(p_shift), .phase_reload_n(p_reload_n), .reconf_clk(r_clk),
      .reconf_ctrl(r_ctrl), .reconf_wbus(r_wbus), .reconf_arst_n(r_arst_n));

   task automatic chk(input logic [32:0] seen, input logic [32:0] exp, input string nm);
      n_checks++;
      if (seen !== exp)
      begin
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
         fails++;
      end
   endtask

   task automatic test_done();
      if (fails == 0 && n_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'h1;
      penable <= 1'h0;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      // only the watchdog ends a wait for the slave
      do
         @(posedge pclk);
      while (pready !== 1'h1);
      q = prdata;
      e = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
      apb(1'h0, a, 32'h0);
      chk(q, exp, nm);
   endtask

   task automatic pause();
      @(posedge pclk);
      #1;
   endtask

   initial
   begin
      pclk = 1'h0;
      forever #5 pclk = ~pclk;
   end

   initial
   begin
      #200000;
      fails++;
      test_done();
   end

   initial
   begin
      fails = 0;
      n_checks = 0;
      {presetn, psel, penable, pwrite, paddr, pwdata} = 44'h0;
      repeat (20) @(posedge pclk);
      presetn <= 1'h1;
      repeat (3) @(posedge pclk);
      rd(pll_adjust_pkg::INIT_ADDR, 32'h80, "init");
      chk(e, 1'h0, "slverr");
      rd(pll_adjust_pkg::DELAY_STATE_ADDR, 32'h80, "tap");
      rd(pll_adjust_pkg::IRQ_MASK_ADDR, 32'h0, "mask");
      chk(irq, 1'h0, "irq");
      apb(1'h1, 8'h14, 32'hffffffff);
      chk(e, 1'h1, "slverr");
      rd(8'h14, 32'h0, "unmapped");
      chk(e, 1'h1, "slverr");
      foreach (steps[i])
      begin
         fabric_model_inst.step(steps[i][9], steps[i][8]);
         rd(pll_adjust_pkg::DELAY_STATE_ADDR, {24'h0, steps[i][7:0]}, "tap");
      end
      apb(1'h1, pll_adjust_pkg::INIT_ADDR, 32'h0005a3fe);
      fabric_model_inst.reload(1'h1);
      fabric_model_inst.step(1'h1, 1'h1);
      rd(pll_adjust_pkg::DELAY_STATE_ADDR, 32'hfe, "tap");
      fabric_model_inst.reload(1'h0);
      fabric_model_inst.step(1'h1, 1'h0);
      chk(d_flag, 1'h1, "flag");
      fabric_model_inst.step(1'h1, 1'h1);
      rd(pll_adjust_pkg::DELAY_STATE_ADDR, 32'h1ff, "tap");
      apb(1'h1, pll_adjust_pkg::INIT_ADDR, 32'h0005a302);
      fabric_model_inst.reload(1'h1);
      fabric_model_inst.reload(1'h0);
      fabric_model_inst.step(1'h0, 1'h1);
      fabric_model_inst.step(1'h0, 1'h0);
      rd(pll_adjust_pkg::DELAY_STATE_ADDR, 32'h100, "tap");
      chk(r_irq, 1'h1, "reconf_irq");
      fabric_model_inst.ack();
      chk(r_irq, 1'h0, "reconf_irq");
      foreach (shifts[i])
      begin
         fabric_model_inst.shift(shifts[i][16:13], shifts[i][12]);
         rd(pll_adjust_pkg::PHASE_STATE_ADDR, {20'h0, shifts[i][11:0]}, "phase");
      end
      fabric_model_inst.preload();
      rd(pll_adjust_pkg::PHASE_STATE_ADDR, 32'h5a3, "phase");
      chk(r_irq, 1'h1, "reconf_irq");
      rd(pll_adjust_pkg::IRQ_STATUS_ADDR, 32'h0f, "status");
      apb(1'h1, pll_adjust_pkg::IRQ_MASK_ADDR, 32'h04);
      pause();
      chk(irq, 1'h1, "irq");
      apb(1'h1, pll_adjust_pkg::IRQ_STATUS_ADDR, 32'h04);
      pause();
      chk(irq, 1'h0, "irq");
      rd(pll_adjust_pkg::IRQ_STATUS_ADDR, 32'h0b, "status");
      fabric_model_inst.link(11'h003, {1'h1, 32'h1});
      fabric_model_inst.link(11'h003, {1'h0, 32'hdeadbeef});
      fabric_model_inst.link(11'h003, {1'h1, 32'h2});
      fabric_model_inst.link(11'h003, {1'h0, 32'h12345678});
      fabric_model_inst.link(11'h003, {1'h1, 32'h1});
      fabric_model_inst.link(11'h001, 33'h0);
      chk(r_rbus, {1'h0, 32'hdeadbeef}, "rbus");
      fabric_model_inst.link(11'h003, {1'h1, 32'h2});
      fabric_model_inst.link(11'h001, 33'h0);
      chk(r_rbus, {1'h0, 32'h12345678}, "rbus");
      rd(pll_adjust_pkg::IRQ_STATUS_ADDR, 32'h1b, "status");
      fabric_model_inst.arst();
      chk(r_rbus, 33'h0, "rbus");
      chk(r_irq, 1'h0, "reconf_irq");
      // word 1 held data before the reset, so a zero proves the store was cleared
      fabric_model_inst.link(11'h003, {1'h1, 32'h1});
      fabric_model_inst.link(11'h001, 33'h0);
      chk(r_rbus, 33'h0, "rbus");
      test_done();
   end
endmodule
